// ===== core_model.sv
/*
  Behavioural processor core issuing one access per cycle to the I/O window.
  Assumes access and idle are called at a falling edge of sys_clk_i.
*/
`timescale 1ns/10ps

module core_model (
  // Clock
  input wire logic sys_clk_i,
  // Request
  output logic req_valid_o,
  output io_space_pkg::access_op_e req_op_o,
  output logic [7:0] req_addr_o,
  output logic [2:0] req_bit_o,
  output logic [7:0] req_wdata_o,
  // Answer
  input wire logic ack_i,
  input wire logic [7:0] rdata_i,
  input wire logic skip_i,
  input wire logic refused_i,
  input wire logic ext_rd_i,
  input wire logic ext_wr_i
);
  logic [7:0] got_rdata;
  logic got_ack, got_skip, got_refused, got_ext_rd, got_ext_wr;

  initial begin
    req_valid_o = 1'b0;
    req_op_o = io_space_pkg::OP_IO_IN;
    req_addr_o = 8'h00;
    req_bit_o = 3'h0;
    req_wdata_o = 8'h00;
  end

  // ----------------------------------------
  // Request held across the taking edge
  // ----------------------------------------
  // Valid stays up so the next call lands back to back
  task automatic access(input io_space_pkg::access_op_e op, input logic [7:0] addr,
                        input logic [2:0] bsel, input logic [7:0] wdata);
    req_valid_o = 1'b1;
    req_op_o = op;
    req_addr_o = addr;
    req_bit_o = bsel;
    req_wdata_o = wdata;
    #1;
    got_ext_rd = ext_rd_i;
    got_ext_wr = ext_wr_i;
    @(negedge sys_clk_i);
    got_ack = ack_i;
    got_rdata = rdata_i;
    got_skip = skip_i;
    got_refused = refused_i;
  endtask : access

  // Released address and data lines carry a changing pattern, never the old value
  task automatic idle();
    req_valid_o = 1'b0;
    req_addr_o = ~req_addr_o;
    req_wdata_o = ~req_wdata_o;
    @(negedge sys_clk_i);
  endtask : idle

endmodule : core_model

// ===== event_flag_reg.sv
/*
  One 8-bit write-one-to-clear status register.
  Assumes set and clear are synchronous to sys_clk_i.
*/
`timescale 1ns/10ps
`include "io_space_defines.svh"

module event_flag_reg #(
  parameter logic [7:0] VALID_MASK = `MASK_FULL
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Events and software clear
  input wire logic [7:0] set_i,
  input wire logic [7:0] clear_i,
  // Current flags
  output logic [7:0] value_o
);

  if (VALID_MASK == `MASK_NONE) begin : g_mask_check
    $error("event_flag_reg needs at least one flag bit");
  end

  wire [7:0] next_value = ((value_o & ~clear_i) | set_i) & VALID_MASK;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Set wins over clear so an event landing on the clear edge survives
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      value_o <= `RESET_VALUE;
    end else begin
      value_o <= next_value;
    end
  end

endmodule : event_flag_reg

// ===== io_space_decode.sv
/*
  Decoder and register file for the 64-location I/O window: direct I/O,
  data-space load/store, single-bit set, clear and test.
  Assumes the core issues at most one access per cycle, synchronous to
  sys_clk_i, and that the extended-range owner answers reads combinationally.
*/
// What this block does
// - Bit set/clear on addresses 0x00 to 0x1F
// - Bit tests skip on selected bit state
// - Writing one clears flags; zero keeps
// - Bit set/clear write back whole register
// - Bit ops refused above address 0x1F
// - I/O ops use addresses 0 to 63
// - Load/store address is I/O plus 0x20
// - Extended range only by load/store
`timescale 1ns/10ps
`include "io_space_defines.svh"

module io_space_decode #(
  parameter int PORT_COUNT = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  // Core access request
  input wire logic req_valid_i,
  input wire io_space_pkg::access_op_e req_op_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [2:0] req_bit_i,
  input wire logic [7:0] req_wdata_i,
  // Core access answer
  output logic ack_o,
  output logic [7:0] rdata_o,
  output logic skip_o,
  output logic refused_o,
  // Extended range owner
  output logic ext_rd_o,
  output logic ext_wr_o,
  input wire logic [7:0] ext_rdata_i,
  // Port pins
  input wire logic [7:0] pin_a_i,
  input wire logic [7:0] pin_b_i,
  input wire logic [7:0] pin_c_i,
  input wire logic [7:0] pin_d_i,
  output logic [7:0] dir_a_o,
  output logic [7:0] dir_b_o,
  output logic [7:0] dir_c_o,
  output logic [7:0] dir_d_o,
  output logic [7:0] latch_a_o,
  output logic [7:0] latch_b_o,
  output logic [7:0] latch_c_o,
  output logic [7:0] latch_d_o,
  // Peripheral event sources
  input wire logic [7:0] tmr0_event_i,
  input wire logic [7:0] tmr1_event_i,
  input wire logic [7:0] tmr2_event_i,
  input wire logic [7:0] tmr3_event_i,
  input wire logic [7:0] pchg_event_i,
  input wire logic [7:0] ext_irq_event_i,
  // Selected control registers
  output logic [7:0] ext_irq_mask_o,
  output logic [7:0] sleep_ctrl_o
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (PORT_COUNT != 4) begin : g_port_count
    $error("io_space_decode maps exactly four ports");
  end

  // ----------------------------------------
  // Operation decode
  // ----------------------------------------
  wire op_io = (req_op_i == io_space_pkg::OP_IO_IN) || (req_op_i == io_space_pkg::OP_IO_OUT);
  wire op_mem = (req_op_i == io_space_pkg::OP_LOAD) || (req_op_i == io_space_pkg::OP_STORE);
  wire op_set = req_op_i == io_space_pkg::OP_SET_BIT;
  wire op_clear = req_op_i == io_space_pkg::OP_CLEAR_BIT;
  wire op_skip_one = req_op_i == io_space_pkg::OP_SKIP_IF_ONE;
  wire op_skip_zero = req_op_i == io_space_pkg::OP_SKIP_IF_ZERO;
  wire op_bit = op_set || op_clear || op_skip_one || op_skip_zero;
  wire op_read = (req_op_i == io_space_pkg::OP_IO_IN) || (req_op_i == io_space_pkg::OP_LOAD);
  wire op_write = (req_op_i == io_space_pkg::OP_IO_OUT) || (req_op_i == io_space_pkg::OP_STORE) ||
                  op_set || op_clear;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Load/store sees the window shifted up by the offset
  wire [7:0] mem_io_addr = req_addr_i - `IO_DATA_OFFSET;
  wire [5:0] io_addr = op_mem ? mem_io_addr[5:0] : req_addr_i[5:0];
  wire mem_in_window = (req_addr_i >= `IO_DATA_OFFSET) && (req_addr_i < `EXT_FIRST);
  wire io_in_window = req_addr_i <= `IO_LAST;
  wire bit_in_window = req_addr_i <= `IO_BIT_LAST;
  wire ext_range = req_addr_i >= `EXT_FIRST;
  wire hit = (op_io && io_in_window) || (op_bit && bit_in_window) || (op_mem && mem_in_window);
  // Only load/store may reach the extended range; I/O and bit ops there are refused
  wire ext_hit = req_valid_i && op_mem && ext_range;
  wire refuse = req_valid_i && ((op_io && !io_in_window) || (op_bit && !bit_in_window) ||
                                (op_mem && (req_addr_i < `IO_DATA_OFFSET)));

  assign ext_rd_o = ext_hit && (req_op_i == io_space_pkg::OP_LOAD);
  assign ext_wr_o = ext_hit && (req_op_i == io_space_pkg::OP_STORE);

  // ----------------------------------------
  // Storage for plain read/write registers
  // ----------------------------------------
  logic [7:0] rw_mem [0:63];
  logic [7:0] tmr0_flags;
  logic [7:0] tmr1_flags;
  logic [7:0] tmr2_flags;
  logic [7:0] tmr3_flags;
  logic [7:0] pchg_flags;
  logic [7:0] ext_irq_flags;

  // Zero mask marks reserved or non-storage locations
  function automatic logic [7:0] rw_mask(input logic [5:0] addr);
    case (addr)
      `OFF_PORT_A_DIR, `OFF_PORT_A_LATCH, `OFF_PORT_B_DIR, `OFF_PORT_B_LATCH,
      `OFF_PORT_C_DIR, `OFF_PORT_C_LATCH, `OFF_PORT_D_DIR, `OFF_PORT_D_LATCH,
      `OFF_SCRATCH_0, `OFF_SCRATCH_1, `OFF_SCRATCH_2, `OFF_NV_VALUE, `OFF_NV_ADDR_LOW,
      `OFF_TMR0_COUNT, `OFF_TMR0_CMP_A, `OFF_TMR0_CMP_B, `OFF_SERIAL_CTRL,
      `OFF_SERIAL_DATA, `OFF_CMP_CTRL, `OFF_DEBUG_DATA: rw_mask = `MASK_FULL;
      `OFF_EXT_IRQ_MASK: rw_mask = `MASK_EXT_IRQ_MASK;
      `OFF_NV_CONTROL: rw_mask = `MASK_NV_CONTROL;
      `OFF_NV_ADDR_HIGH: rw_mask = `MASK_NV_ADDR_HIGH;
      `OFF_PRESCALER_SYNC: rw_mask = `MASK_PRESCALER_SYNC;
      `OFF_TMR0_CTRL_A: rw_mask = `MASK_TMR0_CTRL_A;
      `OFF_TMR0_CTRL_B: rw_mask = `MASK_TMR0_CTRL_B;
      `OFF_SERIAL_STATUS: rw_mask = `MASK_SERIAL_STATUS;
      `OFF_SLEEP_CTRL: rw_mask = `MASK_SLEEP_CTRL;
      default: rw_mask = `MASK_NONE;
    endcase
  endfunction : rw_mask

  // ----------------------------------------
  // Read selection
  // ----------------------------------------
  logic [7:0] read_value;
  always_comb begin
    case (io_addr)
      `OFF_PORT_A_PIN: read_value = pin_a_i;
      `OFF_PORT_B_PIN: read_value = pin_b_i;
      `OFF_PORT_C_PIN: read_value = pin_c_i;
      `OFF_PORT_D_PIN: read_value = pin_d_i;
      `OFF_TMR0_FLAGS: read_value = tmr0_flags;
      `OFF_TMR1_FLAGS: read_value = tmr1_flags;
      `OFF_TMR2_FLAGS: read_value = tmr2_flags;
      `OFF_TMR3_FLAGS: read_value = tmr3_flags;
      `OFF_PCHG_FLAGS: read_value = pchg_flags;
      `OFF_EXT_IRQ_FLAGS: read_value = ext_irq_flags;
      default: read_value = rw_mem[io_addr] & rw_mask(io_addr);
    endcase
  end

  // ----------------------------------------
  // Write value and strobes
  // ----------------------------------------
  wire [7:0] bit_onehot = 8'h01 << req_bit_i;
  // Bit set/clear rewrite all eight bits, so a flag read as one gets cleared
  wire [7:0] write_value = op_set ? (read_value | bit_onehot) :
                           op_clear ? (read_value & ~bit_onehot) : req_wdata_i;
  wire write_en = req_valid_i && hit && op_write;
  wire [7:0] write_mask = rw_mask(io_addr);
  wire rw_write = write_en && (write_mask != `MASK_NONE);
  wire selected_bit = read_value[req_bit_i];
  wire next_skip = (op_skip_one && selected_bit) || (op_skip_zero && !selected_bit);

  // Named strobes, so each flag clear follows every net that it reads
  wire [7:0] flag_wdata = write_en ? write_value : `MASK_NONE;
  wire [7:0] clr_tmr0 = (io_addr == `OFF_TMR0_FLAGS) ? flag_wdata : `MASK_NONE;
  wire [7:0] clr_tmr1 = (io_addr == `OFF_TMR1_FLAGS) ? flag_wdata : `MASK_NONE;
  wire [7:0] clr_tmr2 = (io_addr == `OFF_TMR2_FLAGS) ? flag_wdata : `MASK_NONE;
  wire [7:0] clr_tmr3 = (io_addr == `OFF_TMR3_FLAGS) ? flag_wdata : `MASK_NONE;
  wire [7:0] clr_pchg = (io_addr == `OFF_PCHG_FLAGS) ? flag_wdata : `MASK_NONE;
  wire [7:0] clr_ext_irq = (io_addr == `OFF_EXT_IRQ_FLAGS) ? flag_wdata : `MASK_NONE;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < 64; i++) begin
        rw_mem[i] <= `RESET_VALUE;
      end
    end else if (rw_write) begin
      rw_mem[io_addr] <= write_value & write_mask;
    end
  end

  // ----------------------------------------
  // Event flags
  // ----------------------------------------
  event_flag_reg #(.VALID_MASK(`MASK_TMR0_FLAGS)) tmr0_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(tmr0_event_i),
    .clear_i(clr_tmr0),
    .value_o(tmr0_flags)
  );

  event_flag_reg #(.VALID_MASK(`MASK_TMR1_FLAGS)) tmr1_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(tmr1_event_i),
    .clear_i(clr_tmr1),
    .value_o(tmr1_flags)
  );

  event_flag_reg #(.VALID_MASK(`MASK_TMR2_FLAGS)) tmr2_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(tmr2_event_i),
    .clear_i(clr_tmr2),
    .value_o(tmr2_flags)
  );

  event_flag_reg #(.VALID_MASK(`MASK_TMR3_FLAGS)) tmr3_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(tmr3_event_i),
    .clear_i(clr_tmr3),
    .value_o(tmr3_flags)
  );

  event_flag_reg #(.VALID_MASK(`MASK_PCHG_FLAGS)) pchg_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(pchg_event_i),
    .clear_i(clr_pchg),
    .value_o(pchg_flags)
  );

  event_flag_reg #(.VALID_MASK(`MASK_EXT_IRQ_FLAGS)) ext_irq_flag_reg (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .set_i(ext_irq_event_i),
    .clear_i(clr_ext_irq),
    .value_o(ext_irq_flags)
  );

  // ----------------------------------------
  // Answer to the core
  // ----------------------------------------
  wire [7:0] next_rdata = !(req_valid_i && op_read) ? `MASK_NONE :
                          ext_hit ? ext_rdata_i :
                          hit ? read_value : `MASK_NONE;

  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack_o <= 1'b0;
      rdata_o <= `RESET_VALUE;
      skip_o <= 1'b0;
      refused_o <= 1'b0;
    end else begin
      ack_o <= req_valid_i;
      rdata_o <= next_rdata;
      skip_o <= req_valid_i && hit && next_skip;
      refused_o <= refuse;
    end
  end

  // ----------------------------------------
  // Port and control outputs
  // ----------------------------------------
  assign dir_a_o = rw_mem[`OFF_PORT_A_DIR];
  assign dir_b_o = rw_mem[`OFF_PORT_B_DIR];
  assign dir_c_o = rw_mem[`OFF_PORT_C_DIR];
  assign dir_d_o = rw_mem[`OFF_PORT_D_DIR];
  assign latch_a_o = rw_mem[`OFF_PORT_A_LATCH];
  assign latch_b_o = rw_mem[`OFF_PORT_B_LATCH];
  assign latch_c_o = rw_mem[`OFF_PORT_C_LATCH];
  assign latch_d_o = rw_mem[`OFF_PORT_D_LATCH];
  assign ext_irq_mask_o = rw_mem[`OFF_EXT_IRQ_MASK];
  assign sleep_ctrl_o = rw_mem[`OFF_SLEEP_CTRL];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  bit_set_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_set && (req_addr_i == 8'h02) |=> latch_a_o[$past(req_bit_i)])
    else $error("bit set did not set the port latch bit");

  bit_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_clear && (req_addr_i == 8'h01) |=>
      !dir_a_o[$past(req_bit_i)] && ((dir_a_o | $past(bit_onehot)) == ($past(dir_a_o) | $past(bit_onehot))))
    else $error("bit clear changed the wrong direction bits");

  bit_test_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_skip_one && (req_addr_i == 8'h03) |=> skip_o == $past(pin_b_i[req_bit_i]))
    else $error("skip-if-one disagrees with the tested bit");

  flag_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && (req_op_i == io_space_pkg::OP_IO_OUT) && (req_addr_i == 8'h15) && (tmr0_event_i == 8'h00)
      |=> tmr0_flags == ($past(tmr0_flags) & ~$past(req_wdata_i)))
    else $error("write-one-to-clear flags updated wrongly");

  rmw_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_set && (req_addr_i == 8'h1C) && (ext_irq_event_i == 8'h00)
      |=> ext_irq_flags == 8'h00)
    else $error("bit set left a flag that read as set");

  bit_range_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_bit && (req_addr_i > 8'h1F) |=> refused_o && !skip_o)
    else $error("bit op above the bit window was not refused");

  io_read_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && (req_op_i == io_space_pkg::OP_IO_IN) && (req_addr_i == 8'h1D) |=> rdata_o == $past(ext_irq_mask_o))
    else $error("direct read returned the wrong register");

  load_offset_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && (req_op_i == io_space_pkg::OP_LOAD) && (req_addr_i == 8'h22) |=> rdata_o == $past(latch_a_o))
    else $error("load did not apply the window offset");

  ext_only_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && (req_addr_i >= `EXT_FIRST) |->
      ((ext_rd_o || ext_wr_o) == op_mem) ##1 (refused_o != $past(op_mem)))
    else $error("extended range reached by a non load/store access");

  ext_answer_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (ext_rd_o || ext_wr_o) |=> ack_o && !refused_o)
    else $error("extended load/store was not answered");

  skip_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_skip_zero && (req_addr_i == 8'h06) |=> skip_o == !$past(pin_c_i[req_bit_i]))
    else $error("skip-if-zero disagrees with the tested bit");

  io_high_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_io && (req_addr_i > `IO_LAST) |=> refused_o && (rdata_o == `MASK_NONE))
    else $error("direct access beyond the window was not refused");

  mem_low_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && op_mem && (req_addr_i < `IO_DATA_OFFSET) |=> refused_o && (rdata_o == `MASK_NONE))
    else $error("load/store below the window offset was not refused");

  reserved_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    req_valid_i && (req_op_i == io_space_pkg::OP_LOAD) && (req_addr_i == 8'h2C) |=> rdata_o == 8'h00)
    else $error("reserved location did not read zero");

endmodule : io_space_decode

// ===== io_space_defines.svh
/*
  Constants for the low I/O register window: map offsets, writable-bit
  masks and address limits.
  Assumes it is included by bare name from each design file that needs it.
*/
`ifndef IO_SPACE_DEFINES_SVH
`define IO_SPACE_DEFINES_SVH

// ----------------------------------------
// Address limits
// ----------------------------------------
`define IO_DATA_OFFSET 8'h20
`define IO_BIT_LAST 8'h1F
`define IO_LAST 8'h3F
`define EXT_FIRST 8'h60

// ----------------------------------------
// I/O offsets
// ----------------------------------------
`define OFF_PORT_A_PIN 6'h00
`define OFF_PORT_A_DIR 6'h01
`define OFF_PORT_A_LATCH 6'h02
`define OFF_PORT_B_PIN 6'h03
`define OFF_PORT_B_DIR 6'h04
`define OFF_PORT_B_LATCH 6'h05
`define OFF_PORT_C_PIN 6'h06
`define OFF_PORT_C_DIR 6'h07
`define OFF_PORT_C_LATCH 6'h08
`define OFF_PORT_D_PIN 6'h09
`define OFF_PORT_D_DIR 6'h0A
`define OFF_PORT_D_LATCH 6'h0B
`define OFF_TMR0_FLAGS 6'h15
`define OFF_TMR1_FLAGS 6'h16
`define OFF_TMR2_FLAGS 6'h17
`define OFF_TMR3_FLAGS 6'h18
`define OFF_PCHG_FLAGS 6'h1B
`define OFF_EXT_IRQ_FLAGS 6'h1C
`define OFF_EXT_IRQ_MASK 6'h1D
`define OFF_SCRATCH_0 6'h1E
`define OFF_NV_CONTROL 6'h1F
`define OFF_NV_VALUE 6'h20
`define OFF_NV_ADDR_LOW 6'h21
`define OFF_NV_ADDR_HIGH 6'h22
`define OFF_PRESCALER_SYNC 6'h23
`define OFF_TMR0_CTRL_A 6'h24
`define OFF_TMR0_CTRL_B 6'h25
`define OFF_TMR0_COUNT 6'h26
`define OFF_TMR0_CMP_A 6'h27
`define OFF_TMR0_CMP_B 6'h28
`define OFF_SCRATCH_1 6'h2A
`define OFF_SCRATCH_2 6'h2B
`define OFF_SERIAL_CTRL 6'h2C
`define OFF_SERIAL_STATUS 6'h2D
`define OFF_SERIAL_DATA 6'h2E
`define OFF_CMP_CTRL 6'h30
`define OFF_DEBUG_DATA 6'h31
`define OFF_SLEEP_CTRL 6'h33

// ----------------------------------------
// Implemented bits
// ----------------------------------------
`define MASK_FULL 8'hFF
`define MASK_NONE 8'h00
`define MASK_TMR0_FLAGS 8'h07
`define MASK_TMR1_FLAGS 8'h27
`define MASK_TMR2_FLAGS 8'h07
`define MASK_TMR3_FLAGS 8'h27
`define MASK_PCHG_FLAGS 8'h0F
`define MASK_EXT_IRQ_FLAGS 8'h07
`define MASK_EXT_IRQ_MASK 8'h07
`define MASK_NV_CONTROL 8'h3F
`define MASK_NV_ADDR_HIGH 8'h0F
`define MASK_PRESCALER_SYNC 8'h83
`define MASK_TMR0_CTRL_A 8'hF3
`define MASK_TMR0_CTRL_B 8'hCF
`define MASK_SERIAL_STATUS 8'hC1
`define MASK_SLEEP_CTRL 8'h0F
`define RESET_VALUE 8'h00

`endif

// ===== io_space_pkg.sv
/*
  Types shared by the I/O window decoder and its testbench.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package io_space_pkg;

  // ----------------------------------------
  // Access kinds issued by the core
  // ----------------------------------------
  typedef enum logic [2:0] {
    OP_IO_IN = 3'h0,
    OP_IO_OUT = 3'h1,
    OP_LOAD = 3'h2,
    OP_STORE = 3'h3,
    OP_SET_BIT = 3'h4,
    OP_CLEAR_BIT = 3'h5,
    OP_SKIP_IF_ONE = 3'h6,
    OP_SKIP_IF_ZERO = 3'h7
  } access_op_e;

endpackage : io_space_pkg

// ===== testbench.sv
/*
  Self-checking testbench for the I/O window decoder.
  Assumes the core model drives requests at falling edges.
*/
`timescale 1ns/10ps

module testbench;
  logic sys_clk_i, rstn_i, req_valid, ack, skip, refused, ext_rd, ext_wr;
  io_space_pkg::access_op_e req_op;
  logic [7:0] req_addr, req_wdata, rdata, ext_rdata, pin_b, pin_c, tmr_ev, eirq_ev;
  logic [7:0] dir_a, dir_b, dir_c, dir_d, latch_a, latch_b, latch_c, latch_d, irq_mask, sleep_ctrl;
  logic [2:0] req_bit;
  int fail_count = 0;
  int n_compared = 0;

  // Extended owner answers at once; idle it shows a pattern unlike the answer
  assign ext_rdata = ext_rd ? (req_addr ^ 8'h5A) : ~req_addr;

  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  core_model i_core (.sys_clk_i(sys_clk_i), .req_valid_o(req_valid), .req_op_o(req_op),
    .req_addr_o(req_addr), .req_bit_o(req_bit), .req_wdata_o(req_wdata), .ack_i(ack),
    .rdata_i(rdata), .skip_i(skip), .refused_i(refused), .ext_rd_i(ext_rd), .ext_wr_i(ext_wr));

  io_space_decode i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_valid_i(req_valid),
    .req_op_i(req_op), .req_addr_i(req_addr), .req_bit_i(req_bit), .req_wdata_i(req_wdata),
    .ack_o(ack), .rdata_o(rdata), .skip_o(skip), .refused_o(refused), .ext_rd_o(ext_rd),
    .ext_wr_o(ext_wr), .ext_rdata_i(ext_rdata), .pin_a_i(~pin_b), .pin_b_i(pin_b),
    .pin_c_i(pin_c), .pin_d_i(~pin_c), .dir_a_o(dir_a), .dir_b_o(dir_b), .dir_c_o(dir_c),
    .dir_d_o(dir_d), .latch_a_o(latch_a), .latch_b_o(latch_b), .latch_c_o(latch_c), .latch_d_o(latch_d),
    .tmr0_event_i(tmr_ev), .tmr1_event_i(tmr_ev), .tmr2_event_i(tmr_ev),
    .tmr3_event_i(tmr_ev), .pchg_event_i(eirq_ev), .ext_irq_event_i(eirq_ev),
    .ext_irq_mask_o(irq_mask), .sleep_ctrl_o(sleep_ctrl));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic run(input io_space_pkg::access_op_e op, input logic [7:0] a,
                     input logic [2:0] b, input logic [7:0] d);
    i_core.access(op, a, b, d);
    check("ack", 8'h01, {7'h00, i_core.got_ack});
  endtask : run

  task automatic done(input string name);
    i_core.idle();
    $display("test %s finished", name);
  endtask : done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("dir_a", 8'h00, dir_a);
    check("latch_d", 8'h00, latch_d);
    check("sleep_ctrl", 8'h00, sleep_ctrl);
    run(io_space_pkg::OP_IO_IN, 8'h1E, 3'h0, 8'h00);
    check("scratch", 8'h00, i_core.got_rdata);
    done("reset");
  endtask : t_reset

  task automatic t_io_map();
    run(io_space_pkg::OP_IO_OUT, 8'h02, 3'h0, 8'h3C);
    check("latch_a", 8'h3C, latch_a);
    run(io_space_pkg::OP_IO_IN, 8'h02, 3'h0, 8'h00);
    check("in 02", 8'h3C, i_core.got_rdata);
    run(io_space_pkg::OP_LOAD, 8'h22, 3'h0, 8'h00);
    check("load 22", 8'h3C, i_core.got_rdata);
    run(io_space_pkg::OP_STORE, 8'h24, 3'h0, 8'h81);
    check("dir_b", 8'h81, dir_b);
    run(io_space_pkg::OP_IO_IN, 8'h03, 3'h0, 8'h00);
    check("in 03", 8'h96, i_core.got_rdata);
    run(io_space_pkg::OP_LOAD, 8'h23, 3'h0, 8'h00);
    check("load 23", 8'h96, i_core.got_rdata);
    run(io_space_pkg::OP_STORE, 8'h53, 3'h0, 8'h0A);
    check("sleep_ctrl", 8'h0A, sleep_ctrl);
    run(io_space_pkg::OP_IO_OUT, 8'h05, 3'h0, 8'h12);
    run(io_space_pkg::OP_STORE, 8'h27, 3'h0, 8'h34);
    run(io_space_pkg::OP_IO_OUT, 8'h08, 3'h0, 8'h56);
    run(io_space_pkg::OP_STORE, 8'h2A, 3'h0, 8'h78);
    check("latch_b", 8'h12, latch_b);
    check("dir_c", 8'h34, dir_c);
    check("latch_c", 8'h56, latch_c);
    check("dir_d", 8'h78, dir_d);
    done("io_map");
  endtask : t_io_map

  task automatic t_bits();
    run(io_space_pkg::OP_SET_BIT, 8'h0B, 3'h0, 8'h00);
    run(io_space_pkg::OP_SET_BIT, 8'h0B, 3'h7, 8'h00);
    run(io_space_pkg::OP_CLEAR_BIT, 8'h0B, 3'h0, 8'h00);
    check("latch_d", 8'h80, latch_d);
    run(io_space_pkg::OP_SET_BIT, 8'h1D, 3'h2, 8'h00);
    check("irq_mask", 8'h04, irq_mask);
    run(io_space_pkg::OP_IO_IN, 8'h1D, 3'h0, 8'h00);
    check("in 1D", 8'h04, i_core.got_rdata);
    run(io_space_pkg::OP_IO_OUT, 8'h01, 3'h0, 8'h5F);
    run(io_space_pkg::OP_CLEAR_BIT, 8'h01, 3'h3, 8'h00);
    check("dir_a", 8'h57, dir_a);
    run(io_space_pkg::OP_SET_BIT, 8'h02, 3'h1, 8'h00);
    check("latch_a", 8'h3E, latch_a);
    run(io_space_pkg::OP_SET_BIT, 8'h20, 3'h0, 8'h00);
    check("refused", 8'h01, {7'h00, i_core.got_refused});
    run(io_space_pkg::OP_CLEAR_BIT, 8'h24, 3'h7, 8'h00);
    check("dir_b kept", 8'h81, dir_b);
    run(io_space_pkg::OP_IO_IN, 8'h20, 3'h0, 8'h00);
    check("in 20", 8'h00, i_core.got_rdata);
    done("bits");
  endtask : t_bits

  task automatic t_skip();
    for (int b = 0; b < 8; b++) begin
      run(io_space_pkg::OP_SKIP_IF_ONE, 8'h06, b[2:0], 8'h00);
      check("skip one", {7'h00, pin_c[b]}, {7'h00, i_core.got_skip});
      run(io_space_pkg::OP_SKIP_IF_ZERO, 8'h06, b[2:0], 8'h00);
      check("skip zero", {7'h00, ~pin_c[b]}, {7'h00, i_core.got_skip});
    end
    run(io_space_pkg::OP_SKIP_IF_ONE, 8'h03, 3'h1, 8'h00);
    check("skip pin_b", 8'h01, {7'h00, i_core.got_skip});
    run(io_space_pkg::OP_SKIP_IF_ONE, 8'h26, 3'h0, 8'h00);
    check("skip refused", 8'h01, {7'h00, i_core.got_refused});
    done("skip");
  endtask : t_skip

  task automatic t_flags();
    tmr_ev = 8'hFF;
    eirq_ev = 8'hFF;
    i_core.idle();
    tmr_ev = 8'h00;
    eirq_ev = 8'h00;
    run(io_space_pkg::OP_IO_OUT, 8'h16, 3'h0, 8'h01);
    run(io_space_pkg::OP_IO_IN, 8'h16, 3'h0, 8'h00);
    check("tmr1 flags", 8'h26, i_core.got_rdata);
    run(io_space_pkg::OP_IO_OUT, 8'h15, 3'h0, 8'h00);
    run(io_space_pkg::OP_IO_IN, 8'h15, 3'h0, 8'h00);
    check("tmr0 flags", 8'h07, i_core.got_rdata);
    run(io_space_pkg::OP_IO_IN, 8'h1C, 3'h0, 8'h00);
    check("irq flags", 8'h07, i_core.got_rdata);
    run(io_space_pkg::OP_SET_BIT, 8'h1C, 3'h1, 8'h00);
    run(io_space_pkg::OP_IO_IN, 8'h1C, 3'h0, 8'h00);
    check("irq after set", 8'h00, i_core.got_rdata);
    run(io_space_pkg::OP_SET_BIT, 8'h16, 3'h0, 8'h00);
    run(io_space_pkg::OP_IO_IN, 8'h16, 3'h0, 8'h00);
    check("tmr1 after set", 8'h00, i_core.got_rdata);
    run(io_space_pkg::OP_CLEAR_BIT, 8'h1B, 3'h0, 8'h00);
    run(io_space_pkg::OP_IO_IN, 8'h1B, 3'h0, 8'h00);
    check("pchg after clear", 8'h01, i_core.got_rdata);
    done("flags");
  endtask : t_flags

  task automatic t_ranges();
    run(io_space_pkg::OP_IO_IN, 8'h40, 3'h0, 8'h00);
    check("in 40", 8'h01, {7'h00, i_core.got_refused});
    run(io_space_pkg::OP_IO_OUT, 8'h60, 3'h0, 8'h11);
    check("out 60", 8'h01, {7'h00, i_core.got_refused});
    check("out 60 ext", 8'h00, {7'h00, i_core.got_ext_wr});
    run(io_space_pkg::OP_LOAD, 8'h80, 3'h0, 8'h00);
    check("load 80 ext", 8'h01, {7'h00, i_core.got_ext_rd});
    check("load 80", 8'hDA, i_core.got_rdata);
    run(io_space_pkg::OP_STORE, 8'h90, 3'h0, 8'h33);
    check("store 90 ext", 8'h01, {7'h00, i_core.got_ext_wr});
    run(io_space_pkg::OP_LOAD, 8'h10, 3'h0, 8'h00);
    check("load 10", 8'h01, {7'h00, i_core.got_refused});
    run(io_space_pkg::OP_IO_IN, 8'h0C, 3'h0, 8'h00);
    check("in 0C", 8'h00, i_core.got_rdata);
    run(io_space_pkg::OP_LOAD, 8'h2C, 3'h0, 8'h00);
    check("load 2C", 8'h00, i_core.got_rdata);
    done("ranges");
  endtask : t_ranges

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Under a hundred cycles of traffic; far more than that means a hang
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    complete_run();
  end

  initial begin
    rstn_i = 1'b0;
    tmr_ev = 8'h00;
    eirq_ev = 8'h00;
    pin_b = 8'h96;
    pin_c = 8'hA5;
    repeat (10) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    t_reset();
    t_io_map();
    t_bits();
    t_skip();
    t_flags();
    t_ranges();
    complete_run();
  end

endmodule : testbench
